// ===== logic/wlc_pkg.sv
`default_nettype none
package wlc_pkg;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned ADDR_W    = 10;
    localparam int unsigned LINE_MAX  = 1024;
    // Base clock stands in for the 54 MHz PLL output
    localparam int unsigned CLK_HZ    = 20_000_000;
    localparam int unsigned PLL_HZ    = 54_000_000;
    localparam int unsigned WR_HZ     = 13_500_000;
    localparam int unsigned RD_HZ     = 18_000_000;
    // Phase accumulator steps per clock, scaled to 2^16
    localparam logic [16:0] PH_ONE    = 17'h10000;
    localparam logic [16:0] WR_STEP   = 17'(longint'(WR_HZ) * 65536 / CLK_HZ);
    localparam logic [16:0] RD_STEP   = 17'(longint'(RD_HZ) * 65536 / CLK_HZ);
    // Active line of 702 write samples is read back over 702 read slots
    localparam logic [9:0]  ACT_LEN   = 10'h2BE;
    localparam logic [9:0]  WR_START  = 10'h060;
    localparam logic [9:0]  POS_LEFT  = 10'h060;
    localparam logic [9:0]  POS_CTR   = 10'h0B7;
    localparam logic [9:0]  POS_RIGHT = 10'h10E;
    localparam logic [9:0]  PIX_MAX   = 10'h3FF;
    localparam int unsigned FIFO_D    = 32;

    typedef enum logic [1:0] {
        WLC_MODE_BYPASS_DIRECT = 2'b00,
        WLC_MODE_BYPASS_MEM    = 2'b01,
        WLC_MODE_COMPRESS      = 2'b10
    } wlc_mode_t;

    typedef enum logic [1:0] {
        WLC_POS_LEFT  = 2'b00,
        WLC_POS_CTR   = 2'b01,
        WLC_POS_RIGHT = 2'b10
    } wlc_pos_t;

    // Mux source codes on {select_b, select_a}
    typedef enum logic [1:0] {
        WLC_SRC_FILTER = 2'b00,
        WLC_SRC_DIRECT = 2'b01,
        WLC_SRC_REF    = 2'b10,
        WLC_SRC_SIDE   = 2'b11
    } wlc_src_t;
endpackage
`default_nettype wire

// ===== logic/wlc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module wlc_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             do_wr;
    logic             do_rd;

    assign in_ready_out  = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];

    always_comb begin
        do_wr       = in_valid_in && in_ready_out;
        do_rd       = out_valid_out && out_ready_in;
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    a_no_overflow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        count <= (AW+1)'(DEPTH)) else $error("fifo count exceeds depth");
endmodule
`default_nettype wire

// ===== logic/wlc_line_mem.sv
`timescale 1ns/1ns
`default_nettype none
module wlc_line_mem
    import wlc_pkg::*;
(
    // Clock
    input  wire logic              clk_in,
    // Write port
    input  wire logic              wr_en_in,
    input  wire logic              wr_bank_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [3*DATA_W-1:0] wr_data_in,
    // Read port
    input  wire logic              rd_bank_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [3*DATA_W-1:0]    rd_data_out
);
    // Two line memories per path, three paths stored side by side
    logic [3*DATA_W-1:0] bank0 [LINE_MAX];
    logic [3*DATA_W-1:0] bank1 [LINE_MAX];

    always_ff @(posedge clk_in) begin
        if (wr_en_in && !wr_bank_in) begin
            bank0[wr_addr_in] <= wr_data_in;
        end
        if (wr_en_in && wr_bank_in) begin
            bank1[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= rd_bank_in ? bank1[rd_addr_in] : bank0[rd_addr_in];
    end
endmodule
`default_nettype wire

// ===== logic/wlc_top.sv
`timescale 1ns/1ns
`default_nettype none
module wlc_top
    import wlc_pkg::*;
(
    // Clock and reset
    input  wire logic              SYS_CLK_IN,
    input  wire logic              RST_N_IN,
    // Mode selection
    input  wire logic [1:0]        MODE_IN,
    input  wire logic [1:0]        POSITION_IN,
    // Line reference pin
    input  wire logic              LINE_REFERENCE_IN,
    // Component video in, one sample per clock
    input  wire logic [DATA_W-1:0] LUMA_IN,
    input  wire logic [DATA_W-1:0] BLUE_DIFF_IN,
    input  wire logic [DATA_W-1:0] RED_DIFF_IN,
    // Side panel and clamp reference levels
    input  wire logic [DATA_W-1:0] SIDE_LUMA_IN,
    input  wire logic [DATA_W-1:0] SIDE_BLUE_DIFF_IN,
    input  wire logic [DATA_W-1:0] SIDE_RED_DIFF_IN,
    input  wire logic [DATA_W-1:0] CLAMP_REF_IN,
    // Output stream
    output logic                   VIDEO_VALID_OUT,
    input  wire logic              VIDEO_READY_IN,
    output logic [DATA_W-1:0]      LUMA_OUT,
    output logic [DATA_W-1:0]      BLUE_DIFF_OUT,
    output logic [DATA_W-1:0]      RED_DIFF_OUT,
    // Controller status
    output logic                   MUX_SELECT_A_OUT,
    output logic                   MUX_SELECT_B_OUT,
    output logic                   WRITE_START_OUT,
    output logic                   READ_START_OUT,
    output logic                   WRITE_STROBE_OUT,
    output logic                   READ_STROBE_OUT,
    output logic                   OVERRUN_OUT
);
    localparam int unsigned PW = 3 * DATA_W;

    // Line reference synchroniser
    logic ref_meta;
    logic ref_sync;
    logic ref_prev;
    logic line_start;

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            ref_meta <= LINE_REFERENCE_IN;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
        end
    end

    // Rising edge defines the line, as upstream aligns it to burst key
    assign line_start = ref_sync && !ref_prev;

    // Input video passes two flops as well
    logic [PW-1:0] vid_meta;
    logic [PW-1:0] vid_sync;

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            vid_meta <= '0;
            vid_sync <= '0;
        end else begin
            vid_meta <= {LUMA_IN, BLUE_DIFF_IN, RED_DIFF_IN};
            vid_sync <= vid_meta;
        end
    end

    function automatic logic [16:0] ph_step(input logic [16:0] acc, input logic [16:0] inc);
        ph_step = acc + inc;
    endfunction

    function automatic logic [9:0] read_start(input logic [1:0] pos);
        case (pos)
            WLC_POS_LEFT:  read_start = POS_LEFT;
            WLC_POS_CTR:   read_start = POS_CTR;
            WLC_POS_RIGHT: read_start = POS_RIGHT;
            default:       read_start = POS_CTR;
        endcase
    endfunction

    // Line-locked phase accumulators and pixel counters
    logic [16:0] wr_ph;
    logic [16:0] rd_ph;
    logic [9:0]  wr_tick;
    logic [9:0]  rd_tick;
    logic        wr_bank;
    logic [16:0] next_wr_ph;
    logic [16:0] next_rd_ph;
    logic [9:0]  next_wr_tick;
    logic [9:0]  next_rd_tick;
    logic        next_wr_bank;
    logic        wr_stb;
    logic        rd_stb;
    logic [16:0] wr_sum;
    logic [16:0] rd_sum;
    logic [16:0] rd_inc;
    logic        compress;

    assign compress = (MODE_IN == WLC_MODE_COMPRESS);

    always_comb begin
        rd_inc = compress ? RD_STEP : WR_STEP;
        wr_sum = ph_step(wr_ph, WR_STEP);
        rd_sum = ph_step(rd_ph, rd_inc);
        wr_stb = wr_sum[16];
        rd_stb = rd_sum[16];
        next_wr_ph   = {1'b0, wr_sum[15:0]};
        next_rd_ph   = {1'b0, rd_sum[15:0]};
        next_wr_tick = wr_tick;
        next_rd_tick = rd_tick;
        next_wr_bank = wr_bank;
        if (wr_stb && wr_tick != PIX_MAX) begin
            next_wr_tick = wr_tick + 10'h001;
        end
        if (rd_stb && rd_tick != PIX_MAX) begin
            next_rd_tick = rd_tick + 10'h001;
        end
        if (line_start) begin
            // Both strobes restart in phase with the line edge
            next_wr_ph   = '0;
            next_rd_ph   = '0;
            next_wr_tick = '0;
            next_rd_tick = '0;
            next_wr_bank = !wr_bank;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            wr_ph   <= '0;
            rd_ph   <= '0;
            wr_tick <= PIX_MAX;
            rd_tick <= PIX_MAX;
            wr_bank <= 1'b0;
        end else begin
            wr_ph   <= next_wr_ph;
            rd_ph   <= next_rd_ph;
            wr_tick <= next_wr_tick;
            rd_tick <= next_rd_tick;
            wr_bank <= next_wr_bank;
        end
    end

    // Window decode: only the active part is stored, sync untouched
    logic [9:0] rd_first;
    logic [9:0] rd_len;
    logic       wr_active;
    logic       rd_active;
    logic [9:0] wr_addr;
    logic [9:0] rd_addr;

    always_comb begin
        rd_first  = compress ? read_start(POSITION_IN) : WR_START;
        rd_len    = ACT_LEN;
        wr_active = (wr_tick >= WR_START) && (wr_tick < WR_START + ACT_LEN);
        rd_active = (rd_tick >= rd_first) && (rd_tick < rd_first + rd_len);
        wr_addr   = wr_tick - WR_START;
        rd_addr   = rd_tick - rd_first;
    end

    logic [PW-1:0] mem_q;

    wlc_line_mem u_mem (
        .clk_in      (SYS_CLK_IN),
        .wr_en_in    (wr_stb && wr_active),
        .wr_bank_in  (wr_bank),
        .wr_addr_in  (wr_addr),
        .wr_data_in  (vid_sync),
        .rd_bank_in  (!wr_bank),
        .rd_addr_in  (rd_addr),
        .rd_data_out (mem_q)
    );

    // Mux select timing, aligned with the one-cycle memory latency
    logic     rd_stb_d;
    logic     rd_act_d;
    logic [1:0] src;
    logic [1:0] next_src;
    logic     in_frame;
    logic     next_rd_stb_d;
    logic     next_rd_act_d;

    always_comb begin
        // Frame reaches past the tick counter, so it closes where the count parks
        in_frame      = (rd_tick >= WR_START) && (rd_tick != PIX_MAX);
        next_rd_stb_d = compress ? rd_stb : wr_stb;
        next_rd_act_d = rd_active;
        case (MODE_IN)
            WLC_MODE_BYPASS_DIRECT: next_src = WLC_SRC_DIRECT;
            WLC_MODE_BYPASS_MEM:    next_src = rd_active ? WLC_SRC_FILTER : WLC_SRC_REF;
            WLC_MODE_COMPRESS: begin
                if (rd_active) begin
                    next_src = WLC_SRC_FILTER;
                end else if (in_frame) begin
                    next_src = WLC_SRC_SIDE;
                end else begin
                    next_src = WLC_SRC_REF;
                end
            end
            default:                next_src = WLC_SRC_DIRECT;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            rd_stb_d <= 1'b0;
            rd_act_d <= 1'b0;
            src      <= WLC_SRC_REF;
        end else begin
            rd_stb_d <= next_rd_stb_d;
            rd_act_d <= next_rd_act_d;
            src      <= next_src;
        end
    end

    // Output multiplexer, one source for all three components
    logic [PW-1:0] mux_data;

    always_comb begin
        case (src)
            WLC_SRC_FILTER: mux_data = mem_q;
            WLC_SRC_DIRECT: mux_data = vid_sync;
            WLC_SRC_REF:    mux_data = {3{CLAMP_REF_IN}};
            WLC_SRC_SIDE:   mux_data = {SIDE_LUMA_IN, SIDE_BLUE_DIFF_IN, SIDE_RED_DIFF_IN};
            default:        mux_data = {3{CLAMP_REF_IN}};
        endcase
    end

    // Output buffer, one word per output sample slot
    logic          fifo_in_ready;
    logic          push;
    logic [PW-1:0] fifo_q;
    logic          overrun;
    logic          next_overrun;

    assign push = (MODE_IN == WLC_MODE_BYPASS_DIRECT) ? wr_stb : rd_stb_d;

    wlc_fifo #(
        .WIDTH (PW),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk_in        (SYS_CLK_IN),
        .rst_n_in      (RST_N_IN),
        .in_valid_in   (push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (mux_data),
        .out_valid_out (VIDEO_VALID_OUT),
        .out_ready_in  (VIDEO_READY_IN),
        .out_data_out  (fifo_q)
    );

    // Video timing cannot stall, so a refused sample is flagged sticky
    always_comb begin
        next_overrun = overrun || (push && !fifo_in_ready);
        if (line_start && !(push && !fifo_in_ready)) begin
            next_overrun = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            overrun <= 1'b0;
        end else begin
            overrun <= next_overrun;
        end
    end

    assign LUMA_OUT         = fifo_q[3*DATA_W-1:2*DATA_W];
    assign BLUE_DIFF_OUT    = fifo_q[2*DATA_W-1:DATA_W];
    assign RED_DIFF_OUT     = fifo_q[DATA_W-1:0];
    assign MUX_SELECT_A_OUT = src[0];
    assign MUX_SELECT_B_OUT = src[1];
    assign WRITE_START_OUT  = wr_stb && (wr_tick == WR_START);
    assign READ_START_OUT   = rd_stb && (rd_tick == rd_first);
    assign WRITE_STROBE_OUT = wr_stb;
    assign READ_STROBE_OUT  = rd_stb;
    assign OVERRUN_OUT      = overrun;

    a_bank_swap: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        line_start |=> wr_bank != $past(wr_bank)) else $error("banks did not swap");
    a_wr_restart: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        line_start |=> wr_tick == 10'h000) else $error("write count not restarted");
    a_wr_rate: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        !wr_stb && !line_start |=> wr_stb) else $error("write strobe gap too long");
    a_rd_rate: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        compress && !line_start && !rd_stb |=> rd_stb) else $error("read strobe gap too long");
    a_read_bank: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        line_start |=> u_mem.rd_bank_in == $past(u_mem.wr_bank_in))
        else $error("read bank is not the line just written");
    a_direct_src: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        MODE_IN == WLC_MODE_BYPASS_DIRECT && $stable(MODE_IN) |=> src == WLC_SRC_DIRECT)
        else $error("direct bypass not routed");
    a_side: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        compress && !rd_active && in_frame ##1 compress |-> src == WLC_SRC_SIDE)
        else $error("side panel missing");
    a_start_pos: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        READ_START_OUT && compress && POSITION_IN == WLC_POS_LEFT |-> rd_tick == POS_LEFT)
        else $error("left start wrong");
endmodule
`default_nettype wire

// ===== tb/wlc_source_model.sv
`timescale 1ns/1ns
`default_nettype none
module wlc_source_model
    import wlc_pkg::*;
#(
    parameter int unsigned LINE_CYC  = 1600,
    parameter int unsigned PULSE_CYC = 8
) (
    // Clock
    input  wire logic         clk_in,
    // Line reference
    output logic              line_reference_out,
    output logic [15:0]       line_count_out,
    // Component video levels
    output logic [DATA_W-1:0] luma_out,
    output logic [DATA_W-1:0] blue_diff_out,
    output logic [DATA_W-1:0] red_diff_out
);
    int unsigned cyc;

    initial begin
        cyc = 0;
        line_count_out = 16'h0000;
        line_reference_out = 1'b0;
        luma_out = 8'h10;
        blue_diff_out = 8'hA5;
        red_diff_out = 8'hF0;
    end

    // Flat field, each line with its own levels so late or stale reads show up
    always @(posedge clk_in) begin
        #1;
        cyc = (cyc == LINE_CYC - 1) ? 0 : cyc + 1;
        if (cyc == 0) begin
            line_count_out = line_count_out + 16'h0001;
        end
        // Reference rises with the burst key edge, once per line
        line_reference_out = (cyc < PULSE_CYC);
        luma_out = 8'(line_count_out * 16'h0007 + 16'h0010);
        blue_diff_out = line_count_out[7:0] ^ 8'hA5;
        red_diff_out = 8'hF0 - line_count_out[7:0];
    end
endmodule
`default_nettype wire

// ===== tb/test_widescreen_line_compressor.sv
`timescale 1ns/1ns
`default_nettype none
module test_widescreen_line_compressor;
    import wlc_pkg::*;
    localparam int LINE_CYC = 1600;
    logic              sys_clk;
    logic              rst_n;
    logic [1:0]        mode;
    logic [1:0]        pos;
    logic              ready;
    logic [DATA_W-1:0] side_y;
    logic [DATA_W-1:0] side_b;
    logic [DATA_W-1:0] side_r;
    logic [DATA_W-1:0] clamp;
    logic              line_ref;
    logic [15:0]       line_no;
    logic [DATA_W-1:0] y_in;
    logic [DATA_W-1:0] b_in;
    logic [DATA_W-1:0] r_in;
    logic              valid;
    logic [DATA_W-1:0] y_out;
    logic [DATA_W-1:0] b_out;
    logic [DATA_W-1:0] r_out;
    logic              sel_a;
    logic              sel_b;
    logic              wr_start;
    logic              rd_start;
    logic              wr_stb;
    logic              rd_stb;
    logic              overrun;
    logic [23:0]       lvl [int];
    int                errors;
    int                n_tests;

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    wlc_source_model #(.LINE_CYC(LINE_CYC)) src (
        .clk_in(sys_clk), .line_reference_out(line_ref), .line_count_out(line_no),
        .luma_out(y_in), .blue_diff_out(b_in), .red_diff_out(r_in));

    wlc_top dut (
        .SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .MODE_IN(mode), .POSITION_IN(pos),
        .LINE_REFERENCE_IN(line_ref), .LUMA_IN(y_in), .BLUE_DIFF_IN(b_in),
        .RED_DIFF_IN(r_in), .SIDE_LUMA_IN(side_y), .SIDE_BLUE_DIFF_IN(side_b),
        .SIDE_RED_DIFF_IN(side_r), .CLAMP_REF_IN(clamp), .VIDEO_VALID_OUT(valid),
        .VIDEO_READY_IN(ready), .LUMA_OUT(y_out), .BLUE_DIFF_OUT(b_out),
        .RED_DIFF_OUT(r_out), .MUX_SELECT_A_OUT(sel_a), .MUX_SELECT_B_OUT(sel_b),
        .WRITE_START_OUT(wr_start), .READ_START_OUT(rd_start),
        .WRITE_STROBE_OUT(wr_stb), .READ_STROBE_OUT(rd_stb), .OVERRUN_OUT(overrun));

    // Input levels seen per line, for expectations one line later and for direct bypass in the same line
    always @(posedge sys_clk) lvl[int'(line_no)] = {y_in, b_in, r_in};

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_count(input int got, input int lo, input int hi, input string what);
        n_tests++;
        if (got < lo || got > hi) begin
            errors++;
            $display("BAD %0t %s: %0d not in %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    task automatic give_up(input string what);
        errors++;
        $display("BAD %0t %s never came", $time, what);
        conclude();
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic wait_rise();
        logic last;
        last = line_ref;
        for (int i = 0; i < 2 * LINE_CYC; i++) begin
            step(1);
            if (line_ref === 1'b1 && last === 1'b0) return;
            last = line_ref;
        end
        give_up("line reference");
    endtask

    // Strobes counted from entry until the chosen start pulse
    task automatic to_start(input bit rd, output int n);
        n = 0;
        for (int i = 0; i < 3000; i++) begin
            step(1);
            if ((rd ? rd_start : wr_start) === 1'b1) return;
            if ((rd ? rd_stb : wr_stb) === 1'b1) n++;
        end
        give_up("start pulse");
    endtask

    task automatic get_word(output logic [23:0] w);
        for (int i = 0; i < 200; i++) begin
            if (valid === 1'b1) begin
                w = {y_out, b_out, r_out};
                return;
            end
            step(1);
        end
        give_up("valid word");
    endtask

    task automatic s_reset();
        int w;
        int s;
        w = 0;
        s = 0;
        for (int i = 0; i < 12; i++) begin
            step(1);
            w += (wr_stb === 1'b1) ? 1 : 0;
            s += (wr_start === 1'b1 || rd_start === 1'b1) ? 1 : 0;
        end
        cmp_word({21'h0, valid, sel_b, sel_a}, {22'h0, WLC_SRC_REF}, "reset outputs");
        cmp_count(w, 0, 0, "write strobes held in reset");
        cmp_count(s, 0, 0, "start pulses in reset");
        rst_n = 1'b1;
    endtask

    task automatic s_rates(input logic [1:0] m, input longint hz);
        int w;
        int r;
        int ew;
        int er;
        w = 0;
        r = 0;
        mode = m;
        ew = int'(longint'(LINE_CYC) * WR_HZ / CLK_HZ);
        er = int'(longint'(LINE_CYC) * hz / CLK_HZ);
        // One whole line, from the phase restart up to the next line edge
        wait_rise();
        step(2);
        for (int i = 0; i < LINE_CYC; i++) begin
            step(1);
            w += (wr_stb === 1'b1) ? 1 : 0;
            r += (rd_stb === 1'b1) ? 1 : 0;
        end
        cmp_count(w, ew - 1, ew + 1, "write strobe rate");
        cmp_count(r, er - 1, er + 1, "read strobe rate");
    endtask

    task automatic s_write_start();
        int n;
        wait_rise();
        to_start(1'b0, n);
        cmp_count(n, int'(WR_START) - 1, int'(WR_START) + 3, "write start");
    endtask

    task automatic s_line(input logic [1:0] m, input logic [1:0] p, input int exp);
        int n;
        logic [23:0] w;
        mode = m;
        pos = p;
        wait_rise();
        wait_rise();
        to_start(1'b1, n);
        if (m == WLC_MODE_COMPRESS) begin
            cmp_count(n, exp - 1, exp + 3, "read start");
        end
        step(20);
        cmp_word({22'h0, sel_b, sel_a}, {22'h0, WLC_SRC_FILTER}, "active select");
        get_word(w);
        cmp_word(w, lvl[int'(line_no) - 1], "line one late");
    endtask

    task automatic s_side();
        int k;
        logic [23:0] w;
        mode = 2'b10;
        pos = 2'b10;
        wait_rise();
        wait_rise();
        step(20);
        cmp_word({22'h0, sel_b, sel_a}, {22'h0, WLC_SRC_REF}, "reference select");
        get_word(w);
        cmp_word(w, {3{clamp}}, "reference level");
        k = 0;
        for (int i = 0; i < 3000 && k < 150; i++) begin
            step(1);
            k += (rd_stb === 1'b1) ? 1 : 0;
        end
        step(6);
        cmp_word({22'h0, sel_b, sel_a}, {22'h0, WLC_SRC_SIDE}, "side select");
        get_word(w);
        cmp_word(w, {side_y, side_b, side_r}, "side levels");
    endtask

    task automatic s_direct();
        logic [23:0] w;
        mode = 2'b00;
        wait_rise();
        wait_rise();
        step(600);
        cmp_word({22'h0, sel_b, sel_a}, {22'h0, WLC_SRC_DIRECT}, "direct select");
        get_word(w);
        cmp_word(w, lvl[int'(line_no)], "direct levels");
    endtask

    task automatic s_overrun();
        int n;
        mode = 2'b10;
        pos = 2'b00;
        wait_rise();
        cmp_word({23'h0, overrun}, 24'h0, "no overrun while drained");
        ready = 1'b0;
        to_start(1'b1, n);
        step(100);
        cmp_word({22'h0, overrun, valid}, 24'h3, "stalled buffer refuses");
        ready = 1'b1;
        n = 0;
        for (int i = 0; i < 2000 && valid === 1'b1; i++) begin
            step(1);
            n++;
        end
        cmp_count(n, int'(FIFO_D), 1999, "drain length");
        wait_rise();
        step(10);
        cmp_word({23'h0, overrun}, 24'h0, "overrun cleared at line");
    endtask

    initial begin
        errors = 0;
        n_tests = 0;
        rst_n = 1'b0;
        mode = 2'b10;
        pos = 2'b00;
        ready = 1'b1;
        side_y = 8'h5C;
        side_b = 8'h93;
        side_r = 8'h2E;
        clamp = 8'h40;
        s_reset();
        s_rates(2'b10, RD_HZ);
        s_rates(2'b01, WR_HZ);
        s_write_start();
        s_line(2'b10, 2'b00, int'(POS_LEFT));
        s_line(2'b10, 2'b01, int'(POS_CTR));
        s_line(2'b10, 2'b10, int'(POS_RIGHT));
        s_line(2'b01, 2'b00, 0);
        s_side();
        s_direct();
        s_overrun();
        conclude();
    end
endmodule
`default_nettype wire
